// ==== include/rcsq_defs.svh ====
`ifndef RCSQ_DEFS_SVH
`define RCSQ_DEFS_SVH

`define RCSQ_CLK_KHZ        25000
`define RCSQ_INUSE_CYC      32
`define RCSQ_INUSE_LAST     5'h1E
`define RCSQ_TXLOCK_CYC     8'h7F
`define RCSQ_RXSD_MS        3
`define RCSQ_RATE_MS        1
`define RCSQ_RXST_DETECTED  3'h3
`define RCSQ_LTSSM_QUIET    5'h00
`define RCSQ_LTSSM_ACTIVE   5'h01
`define RCSQ_LTSSM_POLLING  5'h02
`define RCSQ_LANES_X1       2'h0
`define RCSQ_LANES_X4       2'h2
`define RCSQ_CORE_62M5      2'h1
`define RCSQ_CORE_125M      2'h2
`define RCSQ_PHY_250M       2'h1
`define RCSQ_PHY_500M       2'h2

`endif

// ==== include/rcsq_pkg.sv ====
package rcsq_pkg;
    typedef enum logic [3:0] {
        SQ_HOLD = 4'h1,
        SQ_WAIT = 4'h2,
        SQ_CNT  = 4'h4,
        SQ_RUN  = 4'h8
    } rcsq_seq_t;

    typedef enum logic [2:0] {
        LT_QUIET  = 3'h1,
        LT_ACTIVE = 3'h2,
        LT_POLL   = 3'h4
    } rcsq_lt_t;

    typedef struct packed {
        logic cfg_rst;
        logic soft_rst;
        logic core_rst_flag;
    } rcsq_rst_t;

    typedef struct packed {
        logic [1:0] core_clk_code;
        logic       if_wide;
        logic [1:0] phy_clk_code;
    } rcsq_clk_t;

    typedef struct packed {
        logic [1:0] lanes;
        logic       gen2;
        logic       low_power;
    } rcsq_cfg_t;
endpackage

// ==== hw/rcsq_sequencer.sv ====
`timescale 1ns/100ps
// Contract
// - after reset pin or power-on release, wait for fabric clock in-use
// - release config and soft resets 32 cycles after in-use asserts
// - after those releases, deassert the core reset flag
// - flag may toggle until link training reaches 0x02
// - receive PLL lock moves training from Detect.Quiet to Detect.Active
// - detection done on status pulse with receive status equal 3
// - after detection, training moves to Polling.Active
// - receive digital reset held until signal detect stable 3 ms
// - power-on release deasserts the active-low serializer reset
// - transmit digital reset held until PLL lock stable 127 cycles
// - PHY-side data crosses into core domain through an async crossing
// - PHY clock 250 MHz first generation, 500 MHz second
// - on rate change PHY clock must be back before 1 ms timeout
// - core clock set by width and rate; 62.5 MHz low-power x1
// - core clock keeps configured rate on downtrain; interface throttles
`include "rcsq_defs.svh"
module rcsq_sequencer #(
    parameter int RX_SD_CYC = `RCSQ_RXSD_MS * `RCSQ_CLK_KHZ,
    parameter int RATE_CYC  = `RCSQ_RATE_MS * `RCSQ_CLK_KHZ
) (
    input  wire logic               clk,
    input  wire logic               nrst,
    input  wire logic               ce,
    input  wire logic               pin_perst_n,
    input  wire logic               por_n,
    input  wire logic               fabric_clk_inuse,
    input  wire logic               rx_pll_locked,
    input  wire logic               rx_signal_detect,
    input  wire logic               tx_pll_locked,
    input  wire logic               phy_clk_alive,
    input  wire logic               phy_xfer_toggle,
    input  wire logic [7:0]         phy_xfer_data,
    input  wire logic               phy_status,
    input  wire logic [2:0]         phy_rx_status,
    input  wire rcsq_pkg::rcsq_cfg_t cfg_strap,
    input  wire logic               rate_gen2,
    input  wire rcsq_pkg::rcsq_cfg_t link_actual,
    output rcsq_pkg::rcsq_rst_t     rst_out,
    output logic [4:0]              ltssm_state,
    output logic                    rcv_detect_op,
    output logic                    rx_dig_rst,
    output logic                    serdes_rst_n,
    output logic                    tx_dig_rst,
    output logic [7:0]              core_xfer_data,
    output logic                    core_xfer_valid,
    output rcsq_pkg::rcsq_clk_t     clk_sel,
    output logic                    rate_timeout,
    output logic                    throttle
);
    import rcsq_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);

    localparam int NSYNC = 8;
    logic [NSYNC-1:0] async_in;
    logic [NSYNC-1:0] s1_q;
    logic [NSYNC-1:0] s2_q;
    logic [NSYNC-1:0] s3_q;
    logic [NSYNC-1:0] f_q;

    assign async_in = {phy_xfer_toggle, phy_clk_alive, tx_pll_locked,
                       rx_signal_detect, rx_pll_locked, fabric_clk_inuse,
                       por_n, pin_perst_n};

    // a change is taken only once the second and third stages agree
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    s1_q[gi] <= 1'b0;
                    s2_q[gi] <= 1'b0;
                    s3_q[gi] <= 1'b0;
                    f_q[gi]  <= 1'b0;
                end else if (ce) begin
                    s1_q[gi] <= async_in[gi];
                    s2_q[gi] <= s1_q[gi];
                    s3_q[gi] <= s2_q[gi];
                    if (s2_q[gi] == s3_q[gi]) begin
                        f_q[gi] <= s3_q[gi];
                    end
                end
            end
        end
    endgenerate

    logic perst_f, por_f, inuse_f, rxlock_f, sigdet_f, txlock_f;
    logic alive_f, xtgl_f;
    assign {xtgl_f, alive_f, txlock_f, sigdet_f, rxlock_f, inuse_f,
            por_f, perst_f} = f_q;

    logic rst_in;
    assign rst_in = !perst_f || !por_f;

    rcsq_seq_t  seq_q;
    rcsq_lt_t   lt_q;
    logic [4:0] cnt_q;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            seq_q <= SQ_HOLD;
            cnt_q <= 5'h00;
        end else if (ce) begin
            case (seq_q)
                SQ_HOLD: begin
                    if (!rst_in) begin
                        seq_q <= SQ_WAIT;
                    end
                end
                SQ_WAIT: begin
                    cnt_q <= 5'h00;
                    if (rst_in) begin
                        seq_q <= SQ_HOLD;
                    end else if (inuse_f) begin
                        seq_q <= SQ_CNT;
                    end
                end
                SQ_CNT: begin
                    cnt_q <= cnt_q + 5'h01;
                    if (rst_in) begin
                        seq_q <= SQ_HOLD;
                    end else if (!inuse_f) begin
                        seq_q <= SQ_WAIT;
                    end else if (cnt_q == `RCSQ_INUSE_LAST) begin
                        seq_q <= SQ_RUN;
                    end
                end
                SQ_RUN: begin
                    if (rst_in) begin
                        seq_q <= SQ_HOLD;
                    end else if (!inuse_f && lt_q != LT_POLL) begin
                        // flag may bounce until receivers are found
                        seq_q <= SQ_WAIT;
                    end
                end
                default: seq_q <= SQ_HOLD;
            endcase
        end
    end

    AST_TOGGLE_WINDOW: assert property (
        seq_q == SQ_RUN && lt_q == LT_POLL && !rst_in && ce
        |=> seq_q == SQ_RUN)
        else $error("flag bounced after receivers detected");

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rst_out <= '{cfg_rst: 1'b1, soft_rst: 1'b1, core_rst_flag: 1'b1};
        end else if (ce) begin
            rst_out.cfg_rst       <= !(seq_q == SQ_RUN);
            rst_out.soft_rst      <= !(seq_q == SQ_RUN);
            // flag trails the internal resets out, but returns with them
            rst_out.core_rst_flag <= rst_out.cfg_rst ||
                                     seq_q != SQ_RUN;
        end
    end

    AST_WAIT_INUSE: assert property (
        $fell(rst_out.cfg_rst) |-> $past(inuse_f))
        else $error("config reset released without in-use");
    AST_32_CYCLES: assert property (
        $fell(rst_out.cfg_rst) |-> $past(cnt_q) == 5'(`RCSQ_INUSE_CYC - 1))
        else $error("config reset not released after 32 cycles");
    AST_FLAG_AFTER: assert property (
        !rst_out.core_rst_flag |-> !rst_out.cfg_rst && !rst_out.soft_rst)
        else $error("flag released before internal resets");

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            lt_q <= LT_QUIET;
        end else if (ce) begin
            if (seq_q == SQ_HOLD) begin
                lt_q <= LT_QUIET;
            end else begin
                case (lt_q)
                    LT_QUIET: begin
                        if (rxlock_f) begin
                            lt_q <= LT_ACTIVE;
                        end
                    end
                    LT_ACTIVE: begin
                        if (phy_status &&
                            phy_rx_status == `RCSQ_RXST_DETECTED) begin
                            lt_q <= LT_POLL;
                        end
                    end
                    LT_POLL: lt_q <= LT_POLL;
                    default: lt_q <= LT_QUIET;
                endcase
            end
        end
    end

    AST_QUIET_EXIT: assert property (
        lt_q == LT_QUIET && seq_q != SQ_HOLD && rxlock_f && ce
        |=> lt_q == LT_ACTIVE)
        else $error("training did not leave quiet on pll lock");
    AST_DETECT: assert property (
        $changed(lt_q) && lt_q == LT_POLL |->
        $past(phy_status) && $past(phy_rx_status) == 3'h3)
        else $error("polling entered without receiver detect");

    always_comb begin
        case (lt_q)
            LT_ACTIVE: ltssm_state = `RCSQ_LTSSM_ACTIVE;
            LT_POLL:   ltssm_state = `RCSQ_LTSSM_POLLING;
            default:   ltssm_state = `RCSQ_LTSSM_QUIET;
        endcase
    end
    assign rcv_detect_op = (lt_q == LT_ACTIVE);

    // receive reset comes back if signal detect drops again
    logic [16:0] sd_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sd_cnt_q   <= 17'h00000;
            rx_dig_rst <= 1'b1;
        end else if (ce) begin
            if (!sigdet_f || rst_in) begin
                sd_cnt_q   <= 17'h00000;
                rx_dig_rst <= 1'b1;
            end else if (sd_cnt_q == 17'(RX_SD_CYC - 1)) begin
                rx_dig_rst <= 1'b0;
            end else begin
                sd_cnt_q <= sd_cnt_q + 17'h00001;
            end
        end
    end

    AST_RX_STABLE: assert property (
        $fell(rx_dig_rst) |-> $past(sd_cnt_q) == 17'(RX_SD_CYC - 1)
        && $past(sigdet_f))
        else $error("receive reset released early");

    logic [7:0] tx_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            serdes_rst_n <= 1'b0;
            tx_cnt_q     <= 8'h00;
            tx_dig_rst   <= 1'b1;
        end else if (ce) begin
            serdes_rst_n <= por_f;
            if (!txlock_f || !serdes_rst_n) begin
                tx_cnt_q   <= 8'h00;
                tx_dig_rst <= 1'b1;
            end else if (tx_cnt_q == `RCSQ_TXLOCK_CYC) begin
                tx_dig_rst <= 1'b0;
            end else begin
                tx_cnt_q <= tx_cnt_q + 8'h01;
            end
        end
    end

    AST_SERDES: assert property (ce && por_f |=> serdes_rst_n)
        else $error("serializer reset not released");
    AST_TX_127: assert property (
        $fell(tx_dig_rst) |-> $past(tx_cnt_q) == 8'h7F)
        else $error("transmit reset released before 127 cycles");

    // source holds data steady from its toggle until the next one
    logic xtgl_seen_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            xtgl_seen_q     <= 1'b0;
            core_xfer_data  <= 8'h00;
            core_xfer_valid <= 1'b0;
        end else if (ce) begin
            xtgl_seen_q     <= xtgl_f;
            core_xfer_valid <= xtgl_f != xtgl_seen_q;
            if (xtgl_f != xtgl_seen_q) begin
                core_xfer_data <= phy_xfer_data;
            end
        end
    end

    AST_XFER: assert property (
        core_xfer_valid |-> core_xfer_data == $past(phy_xfer_data))
        else $error("crossing data mismatch");

    // clock plan is caught while the sequencer holds, then frozen
    rcsq_cfg_t cfg_q;
    logic      rate_q;
    logic [16:0] rt_cnt_q;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cfg_q    <= '0;
            clk_sel  <= '0;
            throttle <= 1'b0;
        end else if (ce) begin
            if (seq_q == SQ_HOLD) begin
                cfg_q <= cfg_strap;
            end
            clk_sel.phy_clk_code  <= rate_q ? `RCSQ_PHY_500M
                                            : `RCSQ_PHY_250M;
            clk_sel.core_clk_code <= (cfg_q.lanes == `RCSQ_LANES_X1 &&
                                      !cfg_q.gen2 && cfg_q.low_power)
                                     ? `RCSQ_CORE_62M5
                                     : `RCSQ_CORE_125M;
            clk_sel.if_wide <= cfg_q.lanes == `RCSQ_LANES_X4 &&
                               cfg_q.gen2;
            throttle <= (link_actual.lanes < cfg_q.lanes) ||
                        (cfg_q.gen2 && !link_actual.gen2);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rate_q       <= 1'b0;
            rt_cnt_q     <= 17'h00000;
            rate_timeout <= 1'b0;
        end else if (ce) begin
            rate_q <= rate_gen2;
            if (rate_q != rate_gen2) begin
                rt_cnt_q <= 17'(RATE_CYC);
            end else if (rt_cnt_q != 17'h00000) begin
                rt_cnt_q <= rt_cnt_q - 17'h00001;
                if (rt_cnt_q == 17'h00001 && !alive_f) begin
                    rate_timeout <= 1'b1;
                end
            end
        end
    end

endmodule

// ==== tb/rcsq_app_model.sv ====
`timescale 1ns/100ps
// application-side reset former standing beside the core
module rcsq_app_model (
    input  wire logic clk,
    input  wire logic nrst,
    input  wire logic core_rst_flag,
    input  wire logic fabric_clk_inuse,
    output logic      app_rst_n
);
    logic [4:0] cnt_q;

    // any flag pulse restarts the count, so early toggling is harmless
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q     <= 5'h00;
            app_rst_n <= 1'b0;
        end else if (core_rst_flag || !fabric_clk_inuse) begin
            cnt_q     <= 5'h00;
            app_rst_n <= 1'b0;
        end else if (cnt_q == 5'h1F) begin
            app_rst_n <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 5'h01;
        end
    end
endmodule

// ==== tb/rcsq_sequencer_tb_top.sv ====
`timescale 1ns/100ps
module rcsq_sequencer_tb_top;
    import rcsq_pkg::*;
    localparam int RXSD = 20;
    // rows: rx status in [7:5], expected training state in [4:0]
    localparam logic [7:0] LT_ROWS [4] = '{8'h21, 8'h41, 8'hE1, 8'h62};
    logic       clk, nrst, perst_n, por_n, inuse, rxlock, sigdet, txlock;
    logic       alive, tgl, pst, gen2, dcx_v, rxr, srn, txr, tmo, thr;
    logic [7:0] xd, dcx;
    logic [2:0] rxs;
    logic [4:0] lt;
    logic       rdo, app_rst_n;
    rcsq_rst_t  rst_out;
    rcsq_clk_t  csel;
    rcsq_cfg_t  strap, link;
    int         fail_count, compares, cyc, n, m;

    rcsq_sequencer #(.RX_SD_CYC(RXSD), .RATE_CYC(20)) i_dut (
        .clk(clk), .nrst(nrst), .ce(1'b1), .pin_perst_n(perst_n),
        .por_n(por_n), .fabric_clk_inuse(inuse), .rx_pll_locked(rxlock),
        .rx_signal_detect(sigdet), .tx_pll_locked(txlock),
        .phy_clk_alive(alive), .phy_xfer_toggle(tgl), .phy_xfer_data(xd),
        .phy_status(pst), .phy_rx_status(rxs), .cfg_strap(strap),
        .rate_gen2(gen2), .link_actual(link), .rst_out(rst_out),
        .ltssm_state(lt), .rcv_detect_op(rdo), .rx_dig_rst(rxr),
        .serdes_rst_n(srn), .tx_dig_rst(txr), .core_xfer_data(dcx),
        .core_xfer_valid(dcx_v), .clk_sel(csel), .rate_timeout(tmo),
        .throttle(thr));

    rcsq_app_model i_app (.clk(clk), .nrst(nrst),
        .core_rst_flag(rst_out.core_rst_flag),
        .fabric_clk_inuse(inuse), .app_rst_n(app_rst_n));

    task automatic chk(input string nm, input logic [7:0] exp, got);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task automatic step(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            fail_count++;
            summarize();
        end
    end

    initial begin
        {nrst, perst_n, por_n, inuse, rxlock, sigdet, txlock} = 7'h00;
        {tgl, pst, gen2, rxs, xd} = 14'h0000;
        alive = 1'b1;
        fail_count = 0;
        compares = 0;
        strap = 4'h9;
        link = 4'h9;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        step(1);
        chk("rst_out", 8'h07, rst_out);
        chk("serdes_rst_n", 8'h00, srn);
        chk("tx_dig_rst", 8'h01, txr);
        $display("test reset values done");

        @(posedge clk);
        perst_n <= 1'b1;
        por_n <= 1'b1;
        step(8);
        chk("serdes_rst_n", 8'h01, srn);
        chk("rst_out held", 8'h07, rst_out);
        @(posedge clk);
        inuse <= 1'b1;
        m = 0;
        for (n = 1; n < 60 && rst_out.core_rst_flag; n++) begin
            step(1);
            if (!rst_out.cfg_rst && m == 0) m = n;
        end
        chk("cfg release edge", 8'd37, m[7:0]);
        chk("flag release edge", 8'd38, n[7:0] - 8'd1);
        for (n = 0; n < 60 && !app_rst_n; n++) step(1);
        chk("app release", 8'd32, n[7:0]);
        chk("core clk x4 gen1", 8'h02, csel.core_clk_code);
        chk("if width x4 gen1", 8'h00, csel.if_wide);
        chk("no throttle", 8'h00, thr);
        $display("test reset sequence done");

        @(posedge clk);
        pst <= 1'b1;
        rxs <= 3'h3;
        @(posedge clk);
        pst <= 1'b0;
        step(2);
        chk("ltssm quiet", 8'h00, lt);
        @(posedge clk);
        rxlock <= 1'b1;
        step(6);
        chk("ltssm active", 8'h01, lt);
        chk("detect op", 8'h01, rdo);
        foreach (LT_ROWS[i]) begin
            @(posedge clk);
            pst <= 1'b1;
            rxs <= LT_ROWS[i][7:5];
            @(posedge clk);
            pst <= 1'b0;
            step(1);
            chk("ltssm row", {3'h0, LT_ROWS[i][4:0]}, lt);
        end
        $display("test link training done");

        @(posedge clk);
        inuse <= 1'b0;
        step(8);
        chk("flag after polling", 8'h00, rst_out);
        @(posedge clk);
        inuse <= 1'b1;
        sigdet <= 1'b1;
        step(12);
        sigdet <= 1'b0;
        step(8);
        chk("rx_dig_rst restart", 8'h01, rxr);
        sigdet <= 1'b1;
        for (n = 0; n < 60 && rxr; n++) step(1);
        chk("rx reset window", 8'h01, 8'(n >= RXSD && n <= RXSD + 6));
        @(posedge clk);
        txlock <= 1'b1;
        for (n = 0; n < 200 && txr; n++) step(1);
        chk("tx reset window", 8'h01, 8'(n >= 128 && n <= 134));
        $display("test transceiver resets done");

        for (int k = 0; k < 2; k++) begin
            @(posedge clk);
            xd <= k ? 8'h3C : 8'hA5;
            tgl <= ~tgl;
            for (n = 0; n < 10 && dcx_v !== 1'b1; n++) step(1);
            chk("cross latency", 8'd5, n[7:0]);
            chk("cross data", k ? 8'h3C : 8'hA5, dcx);
            step(1);
            chk("cross valid pulse", 8'h00, dcx_v);
            step(6);
        end
        $display("test crossing done");

        @(posedge clk);
        gen2 <= 1'b1;
        step(3);
        chk("phy clk gen2", 8'h02, csel.phy_clk_code);
        step(30);
        chk("no timeout", 8'h00, tmo);
        alive <= 1'b0;
        gen2 <= 1'b0;
        step(3);
        chk("phy clk gen1", 8'h01, csel.phy_clk_code);
        step(30);
        chk("timeout", 8'h01, tmo);
        $display("test rate change done");

        @(posedge clk);
        link <= 4'h5;
        step(2);
        chk("throttle narrow", 8'h01, thr);
        chk("core clk kept", 8'h02, csel.core_clk_code);
        // straps are taken only while the sequencer holds in reset
        @(posedge clk);
        strap <= 4'h1;
        perst_n <= 1'b0;
        step(9);
        chk("rst_out on perst", 8'h07, rst_out);
        chk("ltssm on perst", 8'h00, lt);
        chk("core clk x1 low power", 8'h01, csel.core_clk_code);
        @(posedge clk);
        strap <= 4'hA;
        link <= 4'h8;
        step(3);
        chk("if width x4 gen2", 8'h01, csel.if_wide);
        chk("core clk x4 gen2", 8'h02, csel.core_clk_code);
        chk("throttle slow", 8'h01, thr);
        @(posedge clk);
        perst_n <= 1'b1;
        m = 0;
        for (n = 1; n < 60 && rst_out.core_rst_flag; n++) begin
            step(1);
            if (!rst_out.cfg_rst && m == 0) m = n;
        end
        chk("cfg release again", 8'd38, m[7:0]);
        chk("flag release again", 8'd39, n[7:0] - 8'd1);
        $display("test clock plan and second release done");
        summarize();
    end
endmodule
